// file: shared/burst_counter_pkg.sv
// Constants and types shared by the burst address counter block
package burst_counter_pkg;

   // Default address width and permitted range
   localparam int ADDR_WIDTH_DEFAULT = 17;
   localparam int ADDR_WIDTH_MIN     = 15;
   localparam int ADDR_WIDTH_MAX     = 17;

   // Readback pipeline depth in clock cycles
   localparam int READBACK_STAGES = 1;

   // Wrap flag value after reset (deasserted)
   localparam logic WRAP_FLAG_RESET = 1'b1;

   // Decoded operations
   typedef enum logic [3:0] {
      OP_HOLD      = 4'h0,
      OP_CNT_CLEAR = 4'h1,
      OP_CNT_LOAD  = 4'h2,
      OP_CNT_READ  = 4'h3,
      OP_CNT_INC   = 4'h4,
      OP_MSK_CLEAR = 4'h5,
      OP_MSK_LOAD  = 4'h6,
      OP_MSK_READ  = 4'h7,
      OP_RESERVED  = 4'h8
   } op_type;

endpackage : burst_counter_pkg

// file: logic/burst_op_decode.sv
// Operation decoder for the burst address counter
`timescale 1ns/1ps
module burst_op_decode
   import burst_counter_pkg::*;
(
   input  wire logic                  sel_counter,
   input  wire logic                  clear_n,
   input  wire logic                  strobe_n,
   input  wire logic                  enable_n,
   output burst_counter_pkg::op_type  op
);
   // Clear has priority, then strobe and enable pairs
   always_comb begin
      op = OP_HOLD;
      if (sel_counter) begin
         if (!clear_n) begin
            op = OP_CNT_CLEAR;
         end else if (!strobe_n && !enable_n) begin
            op = OP_CNT_LOAD;
         end else if (!strobe_n) begin
            op = OP_CNT_READ;
         end else if (!enable_n) begin
            op = OP_CNT_INC;
         end else begin
            op = OP_HOLD;
         end
      end else begin
         if (!clear_n) begin
            op = OP_MSK_CLEAR;
         end else if (!strobe_n && !enable_n) begin
            op = OP_MSK_LOAD;
         end else if (!strobe_n) begin
            op = OP_MSK_READ;
         end else begin
            op = OP_RESERVED;
         end
      end
   end
endmodule : burst_op_decode

// file: logic/burst_address_counter_mask.sv
// Per-port burst address counter with wrap mask and mirror
`timescale 1ns/1ps
module burst_address_counter_mask
   import burst_counter_pkg::*;
#(
   parameter int ADDR_WIDTH = burst_counter_pkg::ADDR_WIDTH_DEFAULT
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   input  wire logic                  master_clear_n,
   input  wire logic                  counter_or_mask_sel,
   input  wire logic                  counter_clear_n,
   input  wire logic                  addr_load_strobe_n,
   input  wire logic                  count_enable_n,
   input  wire logic                  chip_sel_low_n,
   input  wire logic                  chip_sel_high,
   input  wire logic [ADDR_WIDTH-1:0] addr_in,
   output logic      [ADDR_WIDTH-1:0] addr_out,
   output logic                       addr_oe,
   output logic                       data_tristate,
   output logic      [ADDR_WIDTH-1:0] array_addr,
   output logic                       wrap_flag_n
);
   import burst_counter_pkg::*;

   // Width check at elaboration: only the documented address widths are served
   if (ADDR_WIDTH < ADDR_WIDTH_MIN || ADDR_WIDTH > ADDR_WIDTH_MAX) begin : g_width_check
      $error("ADDR_WIDTH out of range");
   end

   localparam logic [ADDR_WIDTH-1:0] ALL_ONES  = {ADDR_WIDTH{1'b1}};
   localparam logic [ADDR_WIDTH-1:0] ALL_ZEROS = {ADDR_WIDTH{1'b0}};
   localparam logic [ADDR_WIDTH-1:0] STEP_ONE  = {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
   localparam logic [ADDR_WIDTH-1:0] STEP_TWO  = {{(ADDR_WIDTH-2){1'b0}}, 2'b10};

   // Two-stage synchronisers for pin inputs
   logic                  sel_meta_reg,    sel_reg;
   logic                  clr_meta_reg,    clr_reg;
   logic                  stb_meta_reg,    stb_reg;
   logic                  en_meta_reg,     en_reg;
   logic                  csl_meta_reg,    csl_reg;
   logic                  csh_meta_reg,    csh_reg;
   logic [ADDR_WIDTH-1:0] addr_meta_reg,   addr_sync_reg;
   logic                  master_clear_n_meta_reg,   master_clear_n_sync_reg;

   logic [ADDR_WIDTH-1:0] counter_reg, counter_next;
   logic [ADDR_WIDTH-1:0] mask_reg,    mask_next;
   logic [ADDR_WIDTH-1:0] mirror_reg,  mirror_next;
   logic                  wrap_reg,    wrap_next;
   logic [ADDR_WIDTH-1:0] readback_reg;
   logic                  readback_valid_reg;
   logic                  tristate_reg;
   logic [ADDR_WIDTH-1:0] step;
   logic [ADDR_WIDTH-1:0] incremented;
   logic                  at_top;
   logic                  chip_selected;
   op_type                op;

   // Control pins pass two flops before any decode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_meta_reg  <= 1'b1;
         sel_reg       <= 1'b1;
         clr_meta_reg  <= 1'b1;
         clr_reg       <= 1'b1;
         stb_meta_reg  <= 1'b1;
         stb_reg       <= 1'b1;
         en_meta_reg   <= 1'b1;
         en_reg        <= 1'b1;
         csl_meta_reg  <= 1'b1;
         csl_reg       <= 1'b1;
         csh_meta_reg  <= 1'b0;
         csh_reg       <= 1'b0;
         addr_meta_reg <= ALL_ZEROS;
         addr_sync_reg <= ALL_ZEROS;
      end else if (clk_en) begin
         sel_meta_reg  <= counter_or_mask_sel;
         sel_reg       <= sel_meta_reg;
         clr_meta_reg  <= counter_clear_n;
         clr_reg       <= clr_meta_reg;
         stb_meta_reg  <= addr_load_strobe_n;
         stb_reg       <= stb_meta_reg;
         en_meta_reg   <= count_enable_n;
         en_reg        <= en_meta_reg;
         csl_meta_reg  <= chip_sel_low_n;
         csl_reg       <= csl_meta_reg;
         csh_meta_reg  <= chip_sel_high;
         csh_reg       <= csh_meta_reg;
         addr_meta_reg <= addr_in;
         addr_sync_reg <= addr_meta_reg;
      end
   end

   // Master clear release is synchronised; assertion acts at once
   always_ff @(posedge clk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         master_clear_n_meta_reg <= 1'b0;
         master_clear_n_sync_reg <= 1'b0;
      end else if (clk_en) begin
         master_clear_n_meta_reg <= 1'b1;
         master_clear_n_sync_reg <= master_clear_n_meta_reg;
      end
   end

   burst_op_decode u_decode (
      .sel_counter (sel_reg),
      .clear_n     (clr_reg),
      .strobe_n    (stb_reg),
      .enable_n    (en_reg),
      .op          (op)
   );

   // Increment arithmetic; masked bits take the old value
   always_comb begin
      step        = mask_reg[0] ? STEP_ONE : STEP_TWO;
      incremented = ((counter_reg + step) & mask_reg) | (counter_reg & ~mask_reg);
      at_top      = ((counter_reg | ~mask_reg) == ALL_ONES);
   end

   // Next-state selection per operation
   always_comb begin
      counter_next = counter_reg;
      mask_next    = mask_reg;
      mirror_next  = mirror_reg;
      wrap_next    = wrap_reg;
      case (op)
         OP_CNT_CLEAR: begin
            counter_next = counter_reg & ~mask_reg;
            mirror_next  = counter_reg & ~mask_reg;
            wrap_next    = 1'b1;
         end
         OP_CNT_LOAD: begin
            counter_next = addr_sync_reg;
            mirror_next  = addr_sync_reg;
            wrap_next    = 1'b1;
         end
         OP_CNT_INC: begin
            // Wrap back to mirror rather than roll to zero
            counter_next = at_top ? mirror_reg : incremented;
            wrap_next    = !(((at_top ? mirror_reg : incremented) | ~mask_reg) == ALL_ONES);
         end
         OP_MSK_CLEAR: begin
            mask_next = ALL_ONES;
            wrap_next = 1'b1;
         end
         OP_MSK_LOAD: begin
            mask_next = addr_sync_reg;
            wrap_next = 1'b1;
         end
         default: begin
            counter_next = counter_reg;
         end
      endcase
   end

   // Counter register; master clear acts at once, without a clock
   always_ff @(posedge clk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         counter_reg <= ALL_ZEROS;
      end else if (sys_rst) begin
         counter_reg <= ALL_ZEROS;
      end else if (clk_en && master_clear_n_sync_reg) begin
         counter_reg <= counter_next;
      end
   end

   // Mask register; all ones leaves the whole counter free to run
   always_ff @(posedge clk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         mask_reg <= ALL_ONES;
      end else if (sys_rst) begin
         mask_reg <= ALL_ONES;
      end else if (clk_en && master_clear_n_sync_reg) begin
         mask_reg <= mask_next;
      end
   end

   // Mirror register; keeps the block start so retransmit needs no reload
   always_ff @(posedge clk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         mirror_reg <= ALL_ZEROS;
      end else if (sys_rst) begin
         mirror_reg <= ALL_ZEROS;
      end else if (clk_en && master_clear_n_sync_reg) begin
         mirror_reg <= mirror_next;
      end
   end

   // Wrap flag register; a flop keeps the pin free of decode glitches
   always_ff @(posedge clk or negedge master_clear_n) begin
      if (!master_clear_n) begin
         wrap_reg <= WRAP_FLAG_RESET;
      end else if (sys_rst) begin
         wrap_reg <= WRAP_FLAG_RESET;
      end else if (clk_en && master_clear_n_sync_reg) begin
         wrap_reg <= wrap_next;
      end
   end

   // Chip selection only affects the data-pin tristate, never counting
   assign chip_selected = !csl_reg && csh_reg;

   // Readback data: one stage onto the address lines, held until the next readback
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         readback_reg <= ALL_ZEROS;
      end else if (clk_en) begin
         if (op == OP_CNT_READ) begin
            readback_reg <= counter_reg;
         end else if (op == OP_MSK_READ) begin
            readback_reg <= mask_reg;
         end
      end
   end

   // Address drive enable, high for one cycle per readback cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         readback_valid_reg <= 1'b0;
      end else if (clk_en) begin
         readback_valid_reg <= (op == OP_CNT_READ) || (op == OP_MSK_READ);
      end
   end

   // Data pins float during a readback while the port is selected
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tristate_reg <= 1'b0;
      end else if (clk_en) begin
         tristate_reg <= ((op == OP_CNT_READ) || (op == OP_MSK_READ)) && chip_selected;
      end
   end

   // Outputs; wrap flag is a flop so it may drive clear directly
   assign addr_out      = readback_reg;
   assign addr_oe       = readback_valid_reg;
   assign data_tristate = tristate_reg;
   assign array_addr    = counter_reg;
   assign wrap_flag_n   = wrap_reg;

   // Assertions
   a_load_copies_both: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_LOAD) |=> (counter_reg == mirror_reg))
      else $error("load did not fill counter and mirror");

   a_readback_counter: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_CNT_READ) |=> (addr_oe && addr_out == $past(counter_reg)))
      else $error("counter readback wrong");

   a_readback_mask: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_MSK_READ) |=> (addr_oe && addr_out == $past(mask_reg)))
      else $error("mask readback wrong");

   a_tristate_selected: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_CNT_READ && chip_selected) |=> data_tristate)
      else $error("data not tristated on readback");

   a_masked_bits_hold: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC && !at_top)
      |=> ((counter_reg & ~mask_reg) == ($past(counter_reg) & ~mask_reg)))
      else $error("masked bits changed");

   a_step_size: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC && !at_top && mask_reg == ALL_ONES)
      |=> (counter_reg == $past(counter_reg) + STEP_ONE))
      else $error("step by one failed");

   a_wrap_mirror: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC && at_top) |=> (counter_reg == $past(mirror_reg)))
      else $error("no wrap to mirror");

   a_flag_low_top: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (!wrap_flag_n) |-> at_top)
      else $error("wrap flag low off top");

   a_hold_stable: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_HOLD) |=> $stable(counter_reg) && $stable(mask_reg) && $stable(mirror_reg))
      else $error("hold changed registers");

   a_mask_clear: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_MSK_CLEAR) |=> (mask_reg == ALL_ONES && wrap_flag_n))
      else $error("mask clear failed");

   a_load_addr_value: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_LOAD)
      |=> (counter_reg == $past(addr_sync_reg) && mirror_reg == $past(addr_sync_reg)))
      else $error("load value not taken from address lines");

   a_step_two: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC && !at_top && !mask_reg[0])
      |=> (counter_reg[0] == $past(counter_reg[0])
           && (counter_reg & mask_reg) == (($past(counter_reg) + STEP_TWO) & mask_reg)))
      else $error("step by two failed");

   a_flag_low_reach: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC && !at_top && ((incremented | ~mask_reg) == ALL_ONES))
      |=> !wrap_flag_n)
      else $error("wrap flag not low at top");

   a_flag_tracks_result: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_INC)
      |=> (wrap_flag_n == ((counter_reg | ~mask_reg) != ALL_ONES)))
      else $error("wrap flag does not match increment result");

   a_flag_high_ops: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && (op == OP_CNT_CLEAR || op == OP_CNT_LOAD || op == OP_MSK_CLEAR
                                   || op == OP_MSK_LOAD))
      |=> wrap_flag_n)
      else $error("wrap flag not released");

   a_mask_load_value: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_MSK_LOAD)
      |=> (mask_reg == $past(addr_sync_reg)))
      else $error("mask load value wrong");

   a_clear_keeps_masked: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && master_clear_n_sync_reg && op == OP_CNT_CLEAR)
      |=> ((counter_reg & mask_reg) == ALL_ZEROS && mirror_reg == counter_reg
           && (counter_reg & ~mask_reg) == ($past(counter_reg) & ~mask_reg)))
      else $error("counter clear wrong");

   a_reserved_keeps: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_RESERVED)
      |=> ($stable(counter_reg) && $stable(mask_reg) && $stable(mirror_reg) && $stable(wrap_reg)))
      else $error("reserved operation changed state");

   a_tristate_mask_read: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op == OP_MSK_READ && chip_selected) |=> data_tristate)
      else $error("data not tristated on mask readback");

   a_tristate_only_read: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op != OP_CNT_READ && op != OP_MSK_READ) |=> !data_tristate)
      else $error("data tristated without readback");

   a_readback_pulse: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op != OP_CNT_READ && op != OP_MSK_READ) |=> !addr_oe)
      else $error("address lines driven without readback");

   a_mirror_stable: assert property (@(posedge clk) disable iff (sys_rst || !master_clear_n)
      (clk_en && op != OP_CNT_LOAD && op != OP_CNT_CLEAR) |=> $stable(mirror_reg))
      else $error("mirror changed outside load or clear");
endmodule : burst_address_counter_mask

// file: verif/host_port_model.sv
// Host-side model driving the port control strobes and address lines
`timescale 1ns/1ps
module host_port_model #(
   parameter int W = 17
) (
   input  wire logic         clk,
   output logic              counter_or_mask_sel,
   output logic              counter_clear_n,
   output logic              addr_load_strobe_n,
   output logic              count_enable_n,
   output logic              chip_sel_low_n,
   output logic              chip_sel_high,
   output logic [W-1:0]      addr
);
   // Idle levels: counter selected, hold, port deselected
   initial begin
      counter_or_mask_sel = 1'b1;
      counter_clear_n     = 1'b1;
      addr_load_strobe_n  = 1'b1;
      count_enable_n      = 1'b1;
      chip_sel_low_n      = 1'b1;
      chip_sel_high       = 1'b0;
      addr                = '0;
   end

   // One operation per cycle, launched just after the rising edge
   task automatic drive(input logic s, input logic c, input logic b, input logic e, input logic [W-1:0] a);
      @(posedge clk);
      #1;
      counter_or_mask_sel = s;
      counter_clear_n     = c;
      addr_load_strobe_n  = b;
      count_enable_n      = e;
      // Lines not carrying a load are released; flip them so a stale value cannot pass
      if (!b && !e) begin
         addr = a;
      end else begin
         addr = ~addr;
      end
   endtask : drive

   // Chip selects are levels, changed only between operations
   task automatic select(input logic on);
      @(posedge clk);
      #1;
      chip_sel_low_n = !on;
      chip_sel_high  = on;
   endtask : select
endmodule : host_port_model

// file: verif/test_burst_address_counter_mask.sv
// Self-checking bench for the burst address counter block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_burst_address_counter_mask;
   import burst_counter_pkg::*;
   localparam int W = ADDR_WIDTH_DEFAULT;
   localparam logic [W-1:0] ONES = '1;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, master_clear_n = 1'b1;
   logic sel, clr_n, stb_n, en_n, csl_n, csh, addr_oe, data_tristate, wrap_flag_n;
   logic [W-1:0] addr_in, addr_out, array_addr;
   int error_cnt = 0, compares = 0, cycles = 0;

   always #5 clk = ~clk;

   host_port_model #(.W(W)) u_host (.clk(clk), .counter_or_mask_sel(sel), .counter_clear_n(clr_n),
      .addr_load_strobe_n(stb_n), .count_enable_n(en_n), .chip_sel_low_n(csl_n),
      .chip_sel_high(csh), .addr(addr_in));

   burst_address_counter_mask #(.ADDR_WIDTH(W)) u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .master_clear_n(master_clear_n), .counter_or_mask_sel(sel), .counter_clear_n(clr_n),
      .addr_load_strobe_n(stb_n), .count_enable_n(en_n), .chip_sel_low_n(csl_n),
      .chip_sel_high(csh), .addr_in(addr_in), .addr_out(addr_out), .addr_oe(addr_oe),
      .data_tristate(data_tristate), .array_addr(array_addr), .wrap_flag_n(wrap_flag_n));

   // Hang guard: far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   // Wait n edges, then look once outputs have settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : settle

   task automatic hold_op();
      u_host.drive(1'b1, 1'b1, 1'b1, 1'b1, '0);
   endtask : hold_op

   // One load cycle, then hold; result visible three edges after launch
   task automatic load(input logic s, input logic [W-1:0] a);
      u_host.drive(s, 1'b1, 1'b0, 1'b0, a);
      hold_op();
      settle(2);
   endtask : load

   // Readback pulse is searched for within a bounded window
   task automatic readback(input logic s, input logic [W-1:0] exp, input logic tri_exp);
      bit seen;
      seen = 0;
      u_host.drive(s, 1'b1, 1'b0, 1'b1, '0);
      hold_op();
      for (int i = 0; i < 6 && !seen; i++) begin
         settle(1);
         if (addr_oe === 1'b1) begin
            seen = 1;
            `CHK(addr_out, exp)
            `CHK(data_tristate, tri_exp)
         end
      end
      `CHK(seen, 1'b1)
      settle(1);
      `CHK(addr_oe, 1'b0)
   endtask : readback

   // Increment from start s; wraps to s after n steps, hold timed for exactly n + 1 steps
   task automatic inc_check(input logic [W-1:0] s, input int step, input int n);
      u_host.drive(1'b1, 1'b1, 1'b1, 1'b0, '0);
      settle(3);
      for (int k = 1; k <= n + 1; k++) begin
         `CHK(array_addr, (k <= n) ? W'(s + step * k) : s)
         `CHK(wrap_flag_n, (k == n) ? 1'b0 : 1'b1)
         if (k == n - 2) begin
            hold_op();
            #1;
         end else begin
            settle(1);
         end
      end
      `CHK(array_addr, s)
   endtask : inc_check

   task automatic run_inc(input logic [W-1:0] m, input logic [W-1:0] s, input int step, input int n);
      load(1'b0, m);
      load(1'b1, s);
      `CHK(wrap_flag_n, 1'b1)
      inc_check(s, step, n);
   endtask : run_inc

   task automatic t_reset();
      `CHK(array_addr, '0)
      `CHK(wrap_flag_n, 1'b1)
      readback(1'b0, ONES, 1'b0);
   endtask : t_reset

   task automatic t_load_read();
      u_host.select(1'b1);
      load(1'b1, 'h1abcd);
      `CHK(array_addr, W'('h1abcd))
      readback(1'b1, 'h1abcd, 1'b1);
      readback(1'b0, ONES, 1'b1);
      u_host.select(1'b0);
      readback(1'b1, 'h1abcd, 1'b0);
   endtask : t_load_read

   task automatic t_hold();
      load(1'b1, 'h00555);
      for (int i = 0; i < 8; i++) begin
         `CHK(array_addr, W'('h00555))
         settle(1);
      end
      // Increment pins while frozen must leave the counter alone
      @(posedge clk);
      #1;
      clk_en = 1'b0;
      u_host.drive(1'b1, 1'b1, 1'b1, 1'b0, '0);
      settle(4);
      `CHK(array_addr, W'('h00555))
      hold_op();
      clk_en = 1'b1;
      settle(3);
      `CHK(array_addr, W'('h00555))
      readback(1'b0, ONES, 1'b0);
   endtask : t_hold

   // Cleared value must also land in the mirror, seen at the wrap
   task automatic t_clear();
      load(1'b0, 'h0000f);
      load(1'b1, 'h12345);
      u_host.drive(1'b1, 1'b0, 1'b1, 1'b1, '0);
      hold_op();
      settle(2);
      `CHK(array_addr, W'('h12340))
      inc_check('h12340, 1, 15);
   endtask : t_clear

   task automatic t_reserved();
      u_host.drive(1'b0, 1'b1, 1'b1, 1'b0, '0);
      hold_op();
      settle(4);
      `CHK(array_addr, W'('h12340))
      readback(1'b0, 'h0000f, 1'b0);
   endtask : t_reserved

   // Flag is driven low first so the mask reset has something to undo
   task automatic t_mask_reset();
      load(1'b0, 'h00003);
      load(1'b1, 'h00002);
      u_host.drive(1'b1, 1'b1, 1'b1, 1'b0, '0);
      hold_op();
      settle(2);
      `CHK(wrap_flag_n, 1'b0)
      u_host.drive(1'b0, 1'b0, 1'b1, 1'b1, '0);
      hold_op();
      settle(2);
      `CHK(wrap_flag_n, 1'b1)
      readback(1'b0, ONES, 1'b0);
   endtask : t_mask_reset

   task automatic t_master();
      load(1'b0, 'h000ff);
      load(1'b1, 'h0abcd);
      @(posedge clk);
      #1;
      master_clear_n = 1'b0;
      #1;
      `CHK(array_addr, '0)
      `CHK(wrap_flag_n, 1'b1)
      @(posedge clk);
      #1;
      master_clear_n = 1'b1;
      settle(3);
      readback(1'b0, ONES, 1'b0);
   endtask : t_master

   initial begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      settle(2);
      t_reset();
      t_load_read();
      run_inc('h0003f, 'h1ff08, 1, 55);
      run_inc('h0003e, 'h00100, 2, 31);
      run_inc(ONES, 'h1fff0, 1, 15);
      t_hold();
      t_clear();
      t_reserved();
      t_mask_reset();
      t_master();
      end_sim();
   end
endmodule : test_burst_address_counter_mask
